// ==== mccr_clkdiv.sv ====
// Internal clock divider and processor clock output
`timescale 1ns/1ps
module mccr_clkdiv (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] div_ratio,
  input  wire logic       clk_invert,
  output logic            div_tick,
  output logic            proc_clk
);
  logic [4:0] cnt_q;
  logic [4:0] ratio;
  logic       phase_q;

  // Code zero divides by sixteen, not by zero
  assign ratio = (div_ratio == mccr_pkg::DIV_ZERO_CODE) ? mccr_pkg::DIV_MAX
                                                       : {1'b0, div_ratio};

  // ---------------------------------------------------------------
  // Tick every ratio cycles
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q    <= '0;
      div_tick <= 1'b0;
    end else if (cnt_q + 5'h01 >= ratio) begin
      cnt_q    <= '0;
      div_tick <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + 5'h01;
      div_tick <= 1'b0;
    end
  end

  // Inverted output keeps outside rising-edge logic off the sample edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_q  <= 1'b0;
      proc_clk <= 1'b0;
    end else begin
      if (div_tick) begin
        phase_q <= ~phase_q;
      end
      proc_clk <= phase_q ^ clk_invert;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_clk_invert;
    @(posedge clk) disable iff (!rst_n)
      $changed(clk_invert) && !$past(div_tick) |=> $changed(proc_clk);
  endproperty
  a_clk_invert: assert property (p_clk_invert) else $error("clock invert ignored");
endmodule // mccr_clkdiv

// ==== mccr_host_model.sv ====
// Host microcontroller model driving the three-wire serial port
`timescale 1ns/1ps
module mccr_host_model (
  input  wire logic clk,
  output logic      serial_clk,
  output logic      serial_cs_n,
  output logic      serial_din,
  input  wire logic serial_dout
);
  // ---------------------------------------------------------------
  // Idle state
  // ---------------------------------------------------------------
  initial begin
    serial_clk  = 1'b0;
    serial_cs_n = 1'b1;
    serial_din  = 1'b0;
  end
  // Data line toggles while deselected so no stale bit can be taken for real data
  always @(posedge clk) if (serial_cs_n) serial_din <= ~serial_din;
  // ---------------------------------------------------------------
  // Frame driver
  // ---------------------------------------------------------------
  // Half periods of 8 clocks give twice the minimum phase width
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, output logic [23:0] rd);
    logic [31:0] sh;
    sh = {cmd, wd};
    rd = 24'h000000;
    @(posedge clk) serial_cs_n <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk) serial_din <= sh[i];
      repeat (8) @(posedge clk);
      if (i < 24) rd = {rd[22:0], serial_dout};
      serial_clk <= 1'b1;
      repeat (8) @(posedge clk);
      serial_clk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    serial_cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule // mccr_host_model

// ==== mccr_pkg.sv ====
// Constants for the metering configuration and calibration register group
package mccr_pkg;
  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam logic [4:0] IDX_CONFIG       = 5'h00;
  localparam logic [4:0] IDX_CURR_OFFSET  = 5'h01;
  localparam logic [4:0] IDX_CURR_GAIN    = 5'h02;
  localparam logic [4:0] IDX_VOLT_OFFSET  = 5'h03;
  localparam logic [4:0] IDX_VOLT_GAIN    = 5'h04;
  // ---------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------
  localparam logic [23:0] CONFIG_RST      = 24'h000001;
  localparam logic [23:0] OFFSET_RST      = 24'h000000;
  localparam logic [23:0] GAIN_RST        = 24'h400000;
  localparam logic [23:0] CONFIG_MASK     = 24'hFF9FFF;
  // ---------------------------------------------------------------
  // Configuration word fields
  // ---------------------------------------------------------------
  localparam int PHASE_MSB     = 23;
  localparam int PHASE_LSB     = 17;
  localparam int GAIN_SEL_BIT  = 16;
  localparam int OPEN_DRN_BIT  = 15;
  localparam int IRQ_PULSE_BIT = 12;
  localparam int IRQ_POL_BIT   = 11;
  localparam int OVERRIDE_BIT  = 10;
  localparam int PIN_ONE_BIT   = 9;
  localparam int PIN_TWO_BIT   = 8;
  localparam int SWAP_BIT      = 7;
  localparam int VOLT_HPF_BIT  = 6;
  localparam int CURR_HPF_BIT  = 5;
  localparam int CLK_INV_BIT   = 4;
  localparam int DIV_MSB       = 3;
  // ---------------------------------------------------------------
  // Serial command byte
  // ---------------------------------------------------------------
  localparam int CMD_TOP_BIT   = 7;
  localparam int CMD_WRITE_BIT = 6;
  localparam int CMD_IDX_MSB   = 5;
  localparam int CMD_IDX_LSB   = 1;
  localparam int CMD_LOW_BIT   = 0;
  localparam logic [4:0] CMD_LAST_BIT  = 5'h07;
  localparam logic [4:0] DATA_LAST_BIT = 5'h17;
  // ---------------------------------------------------------------
  // Clock divider
  // ---------------------------------------------------------------
  localparam logic [3:0] DIV_ZERO_CODE = 4'h0;
  localparam logic [4:0] DIV_MAX       = 5'h10;
endpackage

// ==== mccr_regs.sv ====
// Configuration and calibration registers behind the three-wire serial port
// Behaviour
// - Config bits 23..17 hold signed phase delay of voltage versus current samples.
// - Config bit 16 selects current gain: zero is ten, one is fifty.
// - Config bit 15 set makes both pulse pins drive low only.
// - Config bits 12..11 pick irq pin: low, high, falling pulse, rising pulse.
// - Config bit 10 set drives pulse pins from bits 9 and 8.
// - Under override first pin shows bit 9, second pin bit 8.
// - Config bit 7 selects alternating active-low pulse format.
// - Config bits 6 and 5 enable voltage and current high-pass filters.
// - Config bit 4 inverts the processor clock output.
// - Config bits 3..0 divide master clock by 1..16, zero means 16.
// - Offset registers 1 and 3 reset to zero, signed fractions.
// - Offset calibration writes measured offset then raises the done flag.
// - Gain registers 2 and 4 reset to unity, unsigned two integer bits.
// - Gain calibration overwrites gain register then raises the done flag.
// - Command byte: bit7 zero, bit6 write, bits5..1 index, bit0 zero.
// - Write data lands in the register only after the 24th clock.
`timescale 1ns/1ps
module mccr_regs (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        serial_clk,
  input  wire logic        serial_cs_n,
  input  wire logic        serial_din,
  output logic             serial_dout,
  input  wire logic        cal_write,
  input  wire logic [4:0]  cal_index,
  input  wire logic [23:0] cal_value,
  input  wire logic        cal_done,
  input  wire logic        done_clear,
  output logic             conversion_done_flag,
  input  wire logic        pulse_gen_one_n,
  input  wire logic        pulse_gen_two_n,
  output logic             first_pulse_pin_o,
  output logic             first_pulse_pin_oe,
  output logic             second_pulse_pin_o,
  output logic             second_pulse_pin_oe,
  input  wire logic        irq_request,
  output logic             irq_pin,
  output logic [6:0]       phase_delay_comp,
  output logic             curr_gain_fifty,
  output logic             pulse_format_swap,
  output logic             volt_highpass_on,
  output logic             curr_highpass_on,
  output logic [23:0]      current_dc_offset,
  output logic [23:0]      current_gain_cal,
  output logic [23:0]      voltage_dc_offset,
  output logic [23:0]      voltage_gain_cal,
  output logic             internal_divided_clock,
  output logic             processor_clock_out
);
  typedef enum logic [1:0] {MCCR_ST_CMD, MCCR_ST_WR, MCCR_ST_RD} mccr_state_t;

  mccr_state_t state_q;
  logic [23:0] config_q;
  logic [23:0] shift_q;
  logic [23:0] out_q;
  logic [4:0]  bit_cnt_q;
  logic [4:0]  register_index_q;
  logic [2:0]  pins_s;
  logic        sclk_prev_q;
  logic        sclk_rise;
  logic        sclk_fall;
  logic [7:0]  cmd_byte;
  logic [23:0] wr_data;
  logic        wr_fire;
  logic        irq_prev_q;
  logic        pin_one_lvl;
  logic        pin_two_lvl;

  // ---------------------------------------------------------------
  // Read multiplexer, unmapped indices read zero
  // ---------------------------------------------------------------
  function automatic logic [23:0] read_mux(input logic [4:0] idx, input logic [23:0] cfg,
                                           input logic [23:0] io, input logic [23:0] ig,
                                           input logic [23:0] vo, input logic [23:0] vg);
    case (idx)
      mccr_pkg::IDX_CONFIG:      read_mux = cfg & mccr_pkg::CONFIG_MASK;
      mccr_pkg::IDX_CURR_OFFSET: read_mux = io;
      mccr_pkg::IDX_CURR_GAIN:   read_mux = ig;
      mccr_pkg::IDX_VOLT_OFFSET: read_mux = vo;
      mccr_pkg::IDX_VOLT_GAIN:   read_mux = vg;
      default:                   read_mux = '0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers and serial clock edges
  // ---------------------------------------------------------------
  mccr_sync #(.W(3), .RST(3'h6)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({serial_cs_n, serial_clk, serial_din}),
    .sync_out (pins_s)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= pins_s[1];
    end
  end

  assign sclk_rise = pins_s[1] & ~sclk_prev_q & ~pins_s[2];
  assign sclk_fall = ~pins_s[1] & sclk_prev_q & ~pins_s[2];
  assign cmd_byte  = {shift_q[6:0], pins_s[0]};
  assign wr_data   = {shift_q[22:0], pins_s[0]};
  assign wr_fire   = sclk_rise && (state_q == MCCR_ST_WR)
                     && (bit_cnt_q == mccr_pkg::DATA_LAST_BIT);

  // ---------------------------------------------------------------
  // Serial command and data sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || pins_s[2]) begin
      state_q          <= MCCR_ST_CMD;
      bit_cnt_q        <= '0;
      shift_q          <= '0;
      register_index_q <= '0;
    end else if (sclk_rise) begin
      shift_q <= wr_data;
      case (state_q)
        MCCR_ST_CMD: begin
          if (bit_cnt_q == mccr_pkg::CMD_LAST_BIT) begin
            bit_cnt_q <= '0;
            // Other command types are not this block's concern
            if (!cmd_byte[mccr_pkg::CMD_TOP_BIT] && !cmd_byte[mccr_pkg::CMD_LOW_BIT]) begin
              register_index_q <= cmd_byte[mccr_pkg::CMD_IDX_MSB:mccr_pkg::CMD_IDX_LSB];
              state_q <= cmd_byte[mccr_pkg::CMD_WRITE_BIT] ? MCCR_ST_WR : MCCR_ST_RD;
            end
          end else begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
          end
        end
        MCCR_ST_WR, MCCR_ST_RD: begin
          if (bit_cnt_q == mccr_pkg::DATA_LAST_BIT) begin
            bit_cnt_q <= '0;
            state_q   <= MCCR_ST_CMD;
          end else begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
          end
        end
        default: begin
          state_q   <= MCCR_ST_CMD;
          bit_cnt_q <= '0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read buffer, MSB first; first falling edge is skipped so bit 23
  // stays valid for the first data rising edge
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_q <= '0;
    end else if (sclk_rise && state_q == MCCR_ST_CMD && bit_cnt_q == mccr_pkg::CMD_LAST_BIT
                 && !cmd_byte[mccr_pkg::CMD_TOP_BIT] && !cmd_byte[mccr_pkg::CMD_LOW_BIT]
                 && !cmd_byte[mccr_pkg::CMD_WRITE_BIT]) begin
      out_q <= read_mux(cmd_byte[mccr_pkg::CMD_IDX_MSB:mccr_pkg::CMD_IDX_LSB], config_q,
                        current_dc_offset, current_gain_cal, voltage_dc_offset,
                        voltage_gain_cal);
    end else if (sclk_fall && state_q == MCCR_ST_RD && bit_cnt_q != '0) begin
      out_q <= {out_q[22:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_dout <= 1'b0;
    end else begin
      serial_dout <= out_q[23];
    end
  end

  // ---------------------------------------------------------------
  // Register file; a serial write beats a calibration write
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      config_q <= mccr_pkg::CONFIG_RST;
    end else if (wr_fire && register_index_q == mccr_pkg::IDX_CONFIG) begin
      config_q <= wr_data & mccr_pkg::CONFIG_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      current_dc_offset <= mccr_pkg::OFFSET_RST;
      voltage_dc_offset <= mccr_pkg::OFFSET_RST;
      current_gain_cal  <= mccr_pkg::GAIN_RST;
      voltage_gain_cal  <= mccr_pkg::GAIN_RST;
    end else if (wr_fire) begin
      case (register_index_q)
        mccr_pkg::IDX_CURR_OFFSET: current_dc_offset <= wr_data;
        mccr_pkg::IDX_CURR_GAIN:   current_gain_cal  <= wr_data;
        mccr_pkg::IDX_VOLT_OFFSET: voltage_dc_offset <= wr_data;
        mccr_pkg::IDX_VOLT_GAIN:   voltage_gain_cal  <= wr_data;
        default: ;
      endcase
    end else if (cal_write) begin
      case (cal_index)
        mccr_pkg::IDX_CURR_OFFSET: current_dc_offset <= cal_value;
        mccr_pkg::IDX_CURR_GAIN:   current_gain_cal  <= cal_value;
        mccr_pkg::IDX_VOLT_OFFSET: voltage_dc_offset <= cal_value;
        mccr_pkg::IDX_VOLT_GAIN:   voltage_gain_cal  <= cal_value;
        default: ;
      endcase
    end
  end

  // Set wins over clear so a finishing calibration is never lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conversion_done_flag <= 1'b0;
    end else if (cal_done) begin
      conversion_done_flag <= 1'b1;
    end else if (done_clear) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Configuration fields to the datapath
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_delay_comp  <= '0;
      curr_gain_fifty   <= 1'b0;
      pulse_format_swap <= 1'b0;
      volt_highpass_on  <= 1'b0;
      curr_highpass_on  <= 1'b0;
    end else begin
      phase_delay_comp  <= config_q[mccr_pkg::PHASE_MSB:mccr_pkg::PHASE_LSB];
      curr_gain_fifty   <= config_q[mccr_pkg::GAIN_SEL_BIT];
      pulse_format_swap <= config_q[mccr_pkg::SWAP_BIT];
      volt_highpass_on  <= config_q[mccr_pkg::VOLT_HPF_BIT];
      curr_highpass_on  <= config_q[mccr_pkg::CURR_HPF_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Energy pulse pins
  // ---------------------------------------------------------------
  assign pin_one_lvl = config_q[mccr_pkg::OVERRIDE_BIT] ? config_q[mccr_pkg::PIN_ONE_BIT]
                                                       : pulse_gen_one_n;
  assign pin_two_lvl = config_q[mccr_pkg::OVERRIDE_BIT] ? config_q[mccr_pkg::PIN_TWO_BIT]
                                                       : pulse_gen_two_n;

  // Open-drain mode relies on an external pull-up for the high level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      first_pulse_pin_o   <= 1'b1;
      second_pulse_pin_o  <= 1'b1;
      first_pulse_pin_oe  <= 1'b0;
      second_pulse_pin_oe <= 1'b0;
    end else begin
      first_pulse_pin_o   <= pin_one_lvl;
      second_pulse_pin_o  <= pin_two_lvl;
      first_pulse_pin_oe  <= ~config_q[mccr_pkg::OPEN_DRN_BIT] | ~pin_one_lvl;
      second_pulse_pin_oe <= ~config_q[mccr_pkg::OPEN_DRN_BIT] | ~pin_two_lvl;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt pin signalling; pulses last one clock cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_prev_q <= 1'b0;
      irq_pin    <= 1'b1;
    end else begin
      irq_prev_q <= irq_request;
      case ({config_q[mccr_pkg::IRQ_PULSE_BIT], config_q[mccr_pkg::IRQ_POL_BIT]})
        2'h0:    irq_pin <= ~irq_request;
        2'h1:    irq_pin <= irq_request;
        2'h2:    irq_pin <= ~(irq_request & ~irq_prev_q);
        2'h3:    irq_pin <= irq_request & ~irq_prev_q;
        default: irq_pin <= 1'b1;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Clock divider
  // ---------------------------------------------------------------
  mccr_clkdiv u_clkdiv (
    .clk        (clk),
    .rst_n      (rst_n),
    .div_ratio  (config_q[mccr_pkg::DIV_MSB:0]),
    .clk_invert (config_q[mccr_pkg::CLK_INV_BIT]),
    .div_tick   (internal_divided_clock),
    .proc_clk   (processor_clock_out)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_reserved_zero;
    (config_q & ~mccr_pkg::CONFIG_MASK) == 24'h000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_config_reset;
    !$past(rst_n) |-> config_q == mccr_pkg::CONFIG_RST && internal_divided_clock == 1'b0;
  endproperty
  a_config_reset: assert property (p_config_reset) else $error("config reset wrong");

  property p_offset_reset;
    !$past(rst_n) |-> {current_dc_offset, voltage_dc_offset} == {2{mccr_pkg::OFFSET_RST}};
  endproperty
  a_offset_reset: assert property (p_offset_reset) else $error("offset reset wrong");

  property p_gain_reset;
    !$past(rst_n) |-> {current_gain_cal, voltage_gain_cal} == {2{mccr_pkg::GAIN_RST}};
  endproperty
  a_gain_reset: assert property (p_gain_reset) else $error("gain reset wrong");

  property p_write_lands;
    wr_fire && register_index_q == mccr_pkg::IDX_VOLT_OFFSET |=> voltage_dc_offset == $past(wr_data);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("serial write lost");

  property p_no_early_write;
    state_q == MCCR_ST_WR && !wr_fire && !cal_write |=> $stable(current_gain_cal);
  endproperty
  a_no_early_write: assert property (p_no_early_write) else $error("early write");

  property p_cal_gain;
    cal_write && !wr_fire && cal_index == mccr_pkg::IDX_CURR_GAIN
      |=> current_gain_cal == $past(cal_value);
  endproperty
  a_cal_gain: assert property (p_cal_gain) else $error("gain cal not stored");

  property p_done_set;
    cal_done |=> conversion_done_flag;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag missed");

  property p_override_pin;
    config_q[10] && $stable(config_q) |=> first_pulse_pin_o == $past(config_q[9])
                                         && second_pulse_pin_o == $past(config_q[8]);
  endproperty
  a_override_pin: assert property (p_override_pin) else $error("override ignored");

  property p_open_drain;
    $past(config_q[mccr_pkg::OPEN_DRN_BIT]) && first_pulse_pin_o |-> !first_pulse_pin_oe;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drives high");

  property p_irq_rise_pulse;
    config_q[12:11] == 2'h3 && $stable(config_q) && $rose(irq_request)
      |=> irq_pin ##1 !irq_pin;
  endproperty
  a_irq_rise_pulse: assert property (p_irq_rise_pulse) else $error("irq pulse wrong");

  property p_cmd_legal;
    state_q == MCCR_ST_CMD ##1 state_q == MCCR_ST_WR |-> !$past(cmd_byte[mccr_pkg::CMD_TOP_BIT]);
  endproperty
  a_cmd_legal: assert property (p_cmd_legal) else $error("bad command accepted");

  c_serial_write: cover property (wr_fire);
  c_serial_read:  cover property (state_q == MCCR_ST_RD && bit_cnt_q == mccr_pkg::DATA_LAST_BIT);
  c_cal_done:     cover property (cal_done ##1 done_clear);
  c_override:     cover property (config_q[10] && config_q[15]);
endmodule // mccr_regs

// ==== mccr_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module mccr_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q   <= RST;
      sync_out <= RST;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // mccr_sync

// ==== meter_config_calib_regs_tb.sv ====
// Self-checking testbench for the configuration and calibration registers
`timescale 1ns/1ps
module meter_config_calib_regs_tb;
  logic        clk, rst_n, serial_clk, serial_cs_n, serial_din, serial_dout;
  logic        cal_write, cal_done, done_clear, conversion_done_flag, irq_request, irq_pin;
  logic        pulse_gen_one_n, pulse_gen_two_n, first_pulse_pin_o, first_pulse_pin_oe;
  logic        second_pulse_pin_o, second_pulse_pin_oe, curr_gain_fifty, pulse_format_swap;
  logic        volt_highpass_on, curr_highpass_on, internal_divided_clock, processor_clock_out;
  logic [4:0]  cal_index;
  logic [6:0]  phase_delay_comp;
  logic [23:0] cal_value, current_dc_offset, current_gain_cal, voltage_dc_offset;
  logic [23:0] voltage_gain_cal, rd;
  int          failures, checked, n, k, t, pc, m [5], ks [3];
  wire logic [95:0] pv = {voltage_gain_cal, voltage_dc_offset, current_gain_cal, current_dc_offset};
  mccr_regs u_mccr_regs (.clk, .rst_n, .serial_clk, .serial_cs_n, .serial_din, .serial_dout,
    .cal_write, .cal_index, .cal_value, .cal_done, .done_clear, .conversion_done_flag,
    .pulse_gen_one_n, .pulse_gen_two_n, .first_pulse_pin_o, .first_pulse_pin_oe,
    .second_pulse_pin_o, .second_pulse_pin_oe, .irq_request, .irq_pin, .phase_delay_comp,
    .curr_gain_fifty, .pulse_format_swap, .volt_highpass_on, .curr_highpass_on,
    .current_dc_offset, .current_gain_cal, .voltage_dc_offset, .voltage_gain_cal,
    .internal_divided_clock, .processor_clock_out);
  mccr_host_model u_mccr_host_model (.clk, .serial_clk, .serial_cs_n, .serial_din, .serial_dout);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string s, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [4:0] idx, input logic [23:0] v);
    u_mccr_host_model.xfer({2'b01, idx, 1'b0}, v, rd);
    if (idx == 5'h00) m[0] = v & mccr_pkg::CONFIG_MASK;
    else if (idx < 5'h05) m[idx] = v;
  endtask
  task automatic rdchk(input logic [4:0] idx);
    u_mccr_host_model.xfer({2'b00, idx, 1'b0}, 24'h000000, rd);
    chk("read", rd, (idx < 5'h05) ? m[idx][23:0] : 24'h000000);
  endtask
  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // About 41 frames of 561 clocks each; the limit leaves ample margin
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    finish_test;
  end
  initial begin
    rst_n = 1'b0;
    cal_write = 1'b0;
    cal_index = 5'h00;
    cal_value = 24'h000000;
    cal_done = 1'b0;
    done_clear = 1'b0;
    pulse_gen_one_n = 1'b1;
    pulse_gen_two_n = 1'b1;
    irq_request = 1'b0;
    failures = 0;
    checked = 0;
    // Last entry codes ratio zero with the processor clock inverted
    ks = '{1, 4, 16};
    m = '{24'h000001, 24'h000000, 24'h400000, 24'h000000, 24'h400000};
    void'($urandom(66));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 6; i++) rdchk(i[4:0]);
    for (int i = 0; i < 3; i++) begin
      wr(5'h00, 24'($urandom));
      rdchk(5'h00);
      chk("phase", {17'h0, phase_delay_comp}, 24'(m[0] >> 17));
      chk("fields", {20'h0, curr_gain_fifty, pulse_format_swap, volt_highpass_on,
        curr_highpass_on}, {20'h0, m[0][16], m[0][7:5]});
    end
    for (int i = 1; i < 5; i++) begin
      wr(i[4:0], 24'($urandom));
      rdchk(i[4:0]);
      @(posedge clk);
      cal_index <= i[4:0];
      cal_value <= 24'($urandom);
      cal_write <= 1'b1;
      cal_done <= (i == 4);
      @(posedge clk);
      cal_write <= 1'b0;
      cal_done <= 1'b0;
      m[i] = cal_value;
      repeat (2) @(posedge clk);
      #1;
      chk("cal", pv[(i - 1) * 24 +: 24], m[i][23:0]);
    end
    chk("flag set", {23'h0, conversion_done_flag}, 24'h000001);
    @(posedge clk) done_clear <= 1'b1;
    @(posedge clk) done_clear <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("flag clr", {23'h0, conversion_done_flag}, 24'h000000);
    @(posedge clk);
    cal_done <= 1'b1;
    done_clear <= 1'b1;
    @(posedge clk);
    cal_done <= 1'b0;
    done_clear <= 1'b0;
    #1;
    chk("flag win", {23'h0, conversion_done_flag}, 24'h000001);
    wr(5'h05, 24'($urandom));
    rdchk(5'h05);
    u_mccr_host_model.xfer(8'h43, 24'hFFFFFF, rd);
    rdchk(5'h01);
    for (int i = 0; i < 4; i++) begin
      wr(5'h00, {8'h00, i[0] ^ i[1], 4'h0, 1'b1, i[1], i[0], 8'h01});
      chk("pin one", {22'h0, first_pulse_pin_oe, first_pulse_pin_oe & first_pulse_pin_o},
        {22'h0, i != 2, (i != 2) & i[1]});
      chk("pin two", {22'h0, second_pulse_pin_oe, second_pulse_pin_oe & second_pulse_pin_o},
        {22'h0, i != 1, (i != 1) & i[0]});
    end
    wr(5'h00, 24'h000001);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pulse_gen_one_n <= 1'($urandom);
      pulse_gen_two_n <= 1'($urandom);
      repeat (3) @(posedge clk);
      #1;
      chk("pins", {22'h0, first_pulse_pin_o, second_pulse_pin_o},
        {22'h0, pulse_gen_one_n, pulse_gen_two_n});
    end
    for (int i = 0; i < 4; i++) begin
      wr(5'h00, 24'(32'h1 | (i << 11)));
      @(posedge clk) irq_request <= 1'b1;
      @(posedge clk);
      #1;
      chk("irq edge", {23'h0, irq_pin}, {23'h0, i[0]});
      repeat (3) @(posedge clk);
      #1;
      chk("irq on", {23'h0, irq_pin}, {23'h0, i[1] ? ~i[0] : i[0]});
      @(posedge clk) irq_request <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk("irq idle", {23'h0, irq_pin}, {23'h0, ~i[0]});
    end
    for (int j = 0; j < 3; j++) begin
      wr(5'h00, 24'(ks[j]));
      k = ((ks[j] & 15) == 0) ? 16 : (ks[j] & 15);
      repeat (16) @(posedge clk);
      #1;
      n = 0;
      t = 0;
      pc = processor_clock_out;
      repeat (96) begin
        @(posedge clk);
        #1;
        n += internal_divided_clock;
        t += (processor_clock_out != pc);
        pc = processor_clock_out;
      end
      chk("ticks", 24'(n), 24'(96 / k));
      chk("toggles", 24'(t), 24'(96 / k));
    end
    @(posedge clk) rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    m = '{24'h000001, 24'h000000, 24'h400000, 24'h000000, 24'h400000};
    repeat (4) @(posedge clk);
    #1;
    chk("flag rst", {23'h0, conversion_done_flag}, 24'h000000);
    for (int i = 0; i < 5; i++) rdchk(i[4:0]);
    finish_test;
  end
endmodule // meter_config_calib_regs_tb
